// file: rtl/spm_cfg.svh
// Purpose: Constants for the serial port mux and link slave
// Assumes: One system clock, link pins sampled into it
// Notes:   Slot map of the 20-bit frame: B1, D, A, B2, D, M
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define SPM_FRAME_BITS 20
`define SPM_SLOT_W     5
`define SPM_SLOT_D1    5'h08
`define SPM_SLOT_A     5'h09
`define SPM_SLOT_B2    5'h0a
`define SPM_SLOT_D2    5'h12
`define SPM_SLOT_LAST  5'h13

// ----------------------------------------------------------------
// Destinations, buffering and sampling
// ----------------------------------------------------------------
`define SPM_DEST_MGMT1 3'h3
`define SPM_DEST_MGMT2 3'h4
`define SPM_DEST_N     5
`define SPM_FIFO_DEPTH 8
`define SPM_SYNC_W     16
`define SPM_PIN_CLK    0
`define SPM_PIN_SYNC   1
`define SPM_PIN_RXD    2
`define SPM_PIN_GRANT  3
`define SPM_PIN_MODEM  4

`endif

// file: rtl/spm_pkg.sv
// Purpose: Types for the serial port mux and link slave
// Assumes: Constants come from spm_cfg.svh
// Notes:   Structs carry grouped pins and settings
package spm_pkg;
  // ----------------------------------------------------------------
  // Modes and settings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    direct_modem_mode, pcm_highway, interchip_link, gci_bus
  } spm_phy_t;

  typedef struct packed {
    spm_phy_t phy;
    logic     serial_ctrl_two_mux;
    logic     serial_ctrl_three_mux;
    logic     echo;
    logic     loop;
  } spm_mode_t;

  typedef struct packed {
    logic [1:0] dchan;
    logic [1:0] b1;
    logic [1:0] b2;
  } spm_route_t;

  // ----------------------------------------------------------------
  // Pin groups and data words
  // ----------------------------------------------------------------
  typedef struct packed { logic rxd; logic rclk; logic cts; logic cd; } spm_modem_in_t;
  typedef struct packed { logic txd; logic rts; } spm_modem_out_t;
  typedef struct packed { logic [2:0] dest; logic bit_v; } spm_rxw_t;
  typedef enum logic [2:0] { k_b1, k_b2, k_d, k_a, k_m } spm_kind_t;
  typedef enum logic { fr_idle, fr_run } spm_frame_t;
endpackage

// file: rtl/spm_port.sv
// Purpose: Serial channel physical interface with link frame slave
// Assumes: Link clock and pins are slow against clk_i (10 MHz)
// Notes:   Only the link framing is built; PCM and GCI just claim pins
//
// Functional notes
// - Four physical modes: direct modem, PCM highway, link, GCI.
// - Direct mode gives each controller its own six modem lines.
// - Any multiplexed mode always places controller one on the bus.
// - Only five combinations: two and three muxed only with one.
// - Baud clock on its own pin when direct, on tx clock when muxed.
// - Echo retransmits the whole received stream, every slot.
// - Loopback feeds transmitted bits back into the receive path.
// - Link frame carries five channels in 20 bits every 125 us.
// - Device is link slave; bit clock is an input from the master.
// - Only the 10-bit frame variant exists, not the 8-bit one.
// - Frame sync pulse starts a frame of 20 bit periods.
// - Transmit line driven only in supported bits, floated otherwise.
// - Receive data taken only in the 20 frame bits.
// - Two bearer strobes, high only in unmasked bearer bits.
// - Device requests signaling slot; master answers with grant.
// - Grant sampled at frame sync; granted data starts in first D bit.
// - Grant loss stops sending; controller resends when grant returns.
// - Bearer mask gates receive bits, and transmit bits unless echo is on.
// - D, B1, B2 routable to controllers; M to mgmt one, A to two.
`timescale 1ns/10ps
`include "spm_cfg.svh"

// ----------------------------------------------------------------
// Receive word FIFO
// ----------------------------------------------------------------
module spm_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = `SPM_FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push_w = in_valid_i & in_ready_o;
  wire              pop_w  = out_valid_o & out_ready_i;

  // Full and empty from wrap bit
  assign in_ready_o  = ~((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid_o = (wr_q != rd_q);
  assign out_data_o  = mem_q[rd_q[AW-1:0]];

  // Pointers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push_w) wr_q <= wr_q + 1'b1;
      if (pop_w) rd_q <= rd_q + 1'b1;
    end
  end

  // Storage
  always_ff @(posedge clk_i) begin
    if (push_w) mem_q[wr_q[AW-1:0]] <= in_data_i;
  end
endmodule // spm_fifo

// ----------------------------------------------------------------
// Top: mode routing, test modes and link slave
// ----------------------------------------------------------------
module spm_port (
  input  wire logic                             clk_i,
  input  wire logic                             rst_n_i,
  input  wire spm_pkg::spm_mode_t               mode_i,
  input  wire spm_pkg::spm_route_t              route_i,
  input  wire logic [15:0]                      bearer_bit_mask_i,
  input  wire logic                             link_bit_clock_i,
  input  wire logic                             link_frame_sync_i,
  input  wire logic                             link_rx_data_i,
  input  wire logic                             dchan_grant_i,
  output logic                                  link_tx_data_o,
  output logic                                  link_tx_oe_o,
  output logic                                  dchan_request_o,
  output logic                                  bearer1_strobe_o,
  output logic                                  bearer2_strobe_o,
  input  wire logic                             ctrl_dchan_pend_i,
  input  wire logic [`SPM_DEST_N-1:0]           ctrl_tx_bit_i,
  output logic      [`SPM_DEST_N-1:0]           tx_take_o,
  output logic                                  dchan_abort_o,
  output logic                                  rx_valid_o,
  input  wire logic                             rx_ready_i,
  output spm_pkg::spm_rxw_t                     rx_word_o,
  output logic                                  rx_overrun_o,
  input  wire spm_pkg::spm_modem_in_t  [2:0]    modem_pin_i,
  output spm_pkg::spm_modem_in_t       [2:0]    modem_ctrl_o,
  input  wire spm_pkg::spm_modem_out_t [2:0]    ctrl_modem_i,
  output spm_pkg::spm_modem_out_t      [2:0]    modem_pin_o,
  input  wire logic [2:0]                       baud_clk_i,
  output logic      [2:0]                       baud_gen_clock_out_o,
  output logic      [2:0]                       tx_clock_pin_o,
  output logic      [2:0]                       scc_muxed_o
);
  import spm_pkg::*;

  // Slot kind of a frame position (10-bit variant only)
  function automatic spm_kind_t kind_of(input logic [4:0] s);
    if (s < `SPM_SLOT_D1) return k_b1;
    if (s == `SPM_SLOT_D1 || s == `SPM_SLOT_D2) return k_d;
    if (s == `SPM_SLOT_A) return k_a;
    if (s < `SPM_SLOT_D2) return k_b2;
    return k_m;
  endfunction

  // Bearer mask bit of a slot, msb first
  function automatic logic mask_on(input logic [4:0] s, input logic [15:0] m);
    logic [4:0] i1;
    logic [4:0] i2;
    i1 = 5'h0f - s;
    i2 = 5'h11 - s;
    if (kind_of(s) == k_b1) return m[i1[3:0]];
    if (kind_of(s) == k_b2) return m[i2[3:0]];
    return 1'b1;
  endfunction

  // Controller that owns a slot
  function automatic logic [2:0] dest_of(input spm_kind_t k, input spm_route_t r);
    unique case (k)
      k_b1:    return {1'b0, r.b1};
      k_b2:    return {1'b0, r.b2};
      k_d:     return {1'b0, r.dchan};
      k_a:     return `SPM_DEST_MGMT2;
      k_m:     return `SPM_DEST_MGMT1;
      default: return `SPM_DEST_MGMT1;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin sampling: three flops, change taken when second and third agree
  // ----------------------------------------------------------------
  logic [`SPM_SYNC_W-1:0] s1_q, s2_q, s3_q, lvl_q;
  wire  [`SPM_SYNC_W-1:0] raw_w = {modem_pin_i, dchan_grant_i, link_rx_data_i,
                                   link_frame_sync_i, link_bit_clock_i};
  wire  [`SPM_SYNC_W-1:0] agree_w = ~(s2_q ^ s3_q);
  // Agreed level now, so a pin that moves with the bit clock is seen at its rise
  wire  [`SPM_SYNC_W-1:0] lvl_d   = (agree_w & s3_q) | (~agree_w & lvl_q);

  // Synchroniser chain and filtered level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= raw_w;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  wire rise_w = agree_w[`SPM_PIN_CLK] & s3_q[`SPM_PIN_CLK] & ~lvl_q[`SPM_PIN_CLK];
  wire fall_w = agree_w[`SPM_PIN_CLK] & ~s3_q[`SPM_PIN_CLK] & lvl_q[`SPM_PIN_CLK];
  wire sync_w = lvl_d[`SPM_PIN_SYNC];
  wire rxd_w  = lvl_d[`SPM_PIN_RXD];
  wire gnt_w  = lvl_d[`SPM_PIN_GRANT];
  spm_modem_in_t [2:0] pin_lvl_w;
  assign pin_lvl_w = lvl_q[`SPM_SYNC_W-1:`SPM_PIN_MODEM];

  // ----------------------------------------------------------------
  // Mode decode and direct modem pins
  // ----------------------------------------------------------------
  // mode combinations
  wire       mux_on_w = (mode_i.phy != direct_modem_mode);
  wire       idl_on_w = (mode_i.phy == interchip_link);
  wire [2:0] mux_w    = {mux_on_w & mode_i.serial_ctrl_three_mux, mux_on_w & mode_i.serial_ctrl_two_mux, mux_on_w};
  spm_modem_in_t  [2:0] mctrl_d;
  spm_modem_out_t [2:0] mpin_d;
  spm_modem_in_t  [2:0] mctrl_q;
  spm_modem_out_t [2:0] mpin_q;
  logic [2:0] baud_q, tx_clock_pin_q, muxed_q;

  for (genvar g = 0; g < 3; g++) begin : g_scc
    // per-controller modem lines with test modes
    assign mpin_d[g].txd = mux_w[g] ? 1'b1 : mode_i.loop ? 1'b1 :
                           mode_i.echo ? pin_lvl_w[g].rxd : ctrl_modem_i[g].txd;
    assign mpin_d[g].rts = ~mux_w[g] & ~mode_i.loop & ctrl_modem_i[g].rts;
    assign mctrl_d[g].rxd  = mux_w[g] ? 1'b1 :
                             mode_i.loop ? ctrl_modem_i[g].txd : pin_lvl_w[g].rxd;
    assign mctrl_d[g].rclk = ~mux_w[g] & pin_lvl_w[g].rclk;
    assign mctrl_d[g].cts  = ~mux_w[g] & (mode_i.loop | pin_lvl_w[g].cts);
    assign mctrl_d[g].cd   = ~mux_w[g] & (mode_i.loop | pin_lvl_w[g].cd);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mctrl_q <= '0;
      mpin_q  <= '1;
      baud_q  <= '0;
      tx_clock_pin_q  <= '0;
      muxed_q <= '0;
    end else begin
      mctrl_q <= mctrl_d;
      mpin_q  <= mpin_d;
      baud_q  <= baud_clk_i & ~mux_w;
      tx_clock_pin_q  <= baud_clk_i & mux_w;
      muxed_q <= mux_w;
    end
  end

  // ----------------------------------------------------------------
  // Link frame slave
  // ----------------------------------------------------------------
  spm_frame_t st_q;
  logic [4:0] slot_q;
  logic       granted_q, txd_q, oe_q, req_q, s1b_q, s2b_q, abort_q, ovr_q;
  logic [`SPM_DEST_N-1:0] take_q;

  // next slot on each bit clock rise
  wire        start_w = rise_w & sync_w;
  wire        nrun_w  = start_w | ((st_q == fr_run) & (slot_q != `SPM_SLOT_LAST));
  wire [4:0]  nslot_w = start_w ? 5'h00 : slot_q + 5'h01;
  wire spm_kind_t nk_w = kind_of(nslot_w);
  wire [2:0]  ndest_w = dest_of(nk_w, route_i);
  wire        ngrant_w = start_w ? gnt_w : granted_q;
  // grant lost inside a D slot ends sending
  wire        coll_w  = rise_w & nrun_w & (nk_w == k_d) & granted_q & ~gnt_w;
  wire        ntx_en_w = nrun_w & (mode_i.echo | (mask_on(nslot_w, bearer_bit_mask_i) &
                         ((nk_w != k_d) | (ngrant_w & ~coll_w & ctrl_dchan_pend_i))));
  wire        ntxd_w  = mode_i.echo ? rxd_w : ctrl_tx_bit_i[ndest_w];
  // receive only in enabled frame bits
  wire spm_kind_t ck_w = kind_of(slot_q);
  wire        rx_bit_w = mode_i.loop ? (oe_q ? txd_q : 1'b1) : rxd_w;
  wire        push_w  = idl_on_w & fall_w & (st_q == fr_run) & mask_on(slot_q, bearer_bit_mask_i);
  spm_rxw_t   push_word_w;
  assign push_word_w = '{dest: dest_of(ck_w, route_i), bit_v: rx_bit_w};

  // Frame state and slot counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q   <= fr_idle;
      slot_q <= '0;
    end else if (!idl_on_w) begin
      st_q   <= fr_idle;
    end else if (rise_w) begin
      st_q   <= nrun_w ? fr_run : fr_idle;
      slot_q <= nslot_w;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_q     <= 1'b0;
      granted_q <= 1'b0;
      abort_q   <= 1'b0;
    end else begin
      req_q     <= idl_on_w & ctrl_dchan_pend_i;
      abort_q   <= idl_on_w & coll_w;
      if (!idl_on_w) granted_q <= 1'b0;
      else if (rise_w) granted_q <= ngrant_w & ~coll_w;
    end
  end

  // line driver, strobes and take pulses
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txd_q  <= 1'b1;
      oe_q   <= 1'b0;
      s1b_q  <= 1'b0;
      s2b_q  <= 1'b0;
      take_q <= '0;
    end else if (!idl_on_w) begin
      oe_q   <= 1'b0;
      s1b_q  <= 1'b0;
      s2b_q  <= 1'b0;
      take_q <= '0;
    end else begin
      take_q <= '0;
      if (rise_w) begin
        txd_q <= ntxd_w;
        oe_q  <= ntx_en_w;
        s1b_q <= nrun_w & (nk_w == k_b1) & mask_on(nslot_w, bearer_bit_mask_i);
        s2b_q <= nrun_w & (nk_w == k_b2) & mask_on(nslot_w, bearer_bit_mask_i);
        if (ntx_en_w && !mode_i.echo) take_q[ndest_w] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive buffering toward the controllers
  // ----------------------------------------------------------------
  logic     f_ready_w, f_valid_w;
  spm_rxw_t f_data_w;
  spm_rxw_t rxw_q;
  logic     rxv_q;
  wire      out_take_w = f_valid_w & (~rxv_q | rx_ready_i);

  spm_fifo #(.WIDTH($bits(spm_rxw_t)), .DEPTH(`SPM_FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push_w),
    .in_ready_o  (f_ready_w),
    .in_data_i   (push_word_w),
    .out_valid_o (f_valid_w),
    .out_ready_i (~rxv_q | rx_ready_i),
    .out_data_o  (f_data_w)
  );

  // Output stage and overrun flag
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rxv_q <= 1'b0;
      rxw_q <= '0;
      ovr_q <= 1'b0;
    end else begin
      if (out_take_w) rxw_q <= f_data_w;
      if (out_take_w) rxv_q <= 1'b1;
      else if (rx_ready_i) rxv_q <= 1'b0;
      if (push_w && !f_ready_w) ovr_q <= 1'b1;
      else if (!idl_on_w) ovr_q <= 1'b0;
    end
  end

  // Outputs
  assign link_tx_data_o = txd_q;
  assign link_tx_oe_o = oe_q;
  assign dchan_request_o = req_q;
  assign bearer1_strobe_o = s1b_q;
  assign bearer2_strobe_o = s2b_q;
  assign tx_take_o = take_q;
  assign dchan_abort_o = abort_q;
  assign rx_valid_o = rxv_q;
  assign rx_word_o = rxw_q;
  assign rx_overrun_o = ovr_q;
  assign modem_ctrl_o = mctrl_q;
  assign modem_pin_o = mpin_q;
  assign baud_gen_clock_out_o = baud_q;
  assign tx_clock_pin_o = tx_clock_pin_q;
  assign scc_muxed_o = muxed_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  float_idle_a: assert property (st_q == fr_idle |-> !link_tx_oe_o)
    else $error("line driven outside frame");
  reset_quiet_a: assert property ($past(!idl_on_w) |-> !oe_q && !s1b_q && !s2b_q)
    else $error("link active without mode");
  strobe_mask_a: assert property (bearer1_strobe_o |-> st_q == fr_run &&
    kind_of(slot_q) == k_b1 && mask_on(slot_q, bearer_bit_mask_i))
    else $error("bearer strobe on masked bit");
  frame_len_a: assert property ($rose(st_q == fr_run) |-> slot_q == 5'h00)
    else $error("frame not starting at slot zero");
  slot_max_a: assert property (st_q == fr_run |-> slot_q <= `SPM_SLOT_LAST)
    else $error("slot beyond frame");
  grant_gate_a: assert property (oe_q && !mode_i.echo && kind_of(slot_q) == k_d
    |-> granted_q)
    else $error("D bit sent without grant");
  abort_drop_a: assert property (dchan_abort_o |-> !granted_q ##1 !dchan_abort_o)
    else $error("grant kept after collision");
  request_a: assert property (dchan_request_o |-> $past(ctrl_dchan_pend_i))
    else $error("request without pending data");
  rx_window_a: assert property (push_w |-> st_q == fr_run)
    else $error("receive outside frame");
  baud_route_a: assert property (!(|(baud_gen_clock_out_o & tx_clock_pin_o)))
    else $error("baud clock on both pins");
  mux_first_a: assert property (|scc_muxed_o[2:1] |-> scc_muxed_o[0])
    else $error("muxed without controller one");

  frame_end_c: cover property (st_q == fr_run && slot_q == `SPM_SLOT_LAST ##1 rise_w);
  abort_c: cover property (dchan_abort_o);
  overrun_c: cover property (rx_overrun_o);
  echo_c: cover property (mode_i.echo && oe_q);
endmodule // spm_port

// file: bench/spm_link_master.sv
// Purpose: Link master model: makes bit clock, frame sync, rx data, grant
// Assumes: Bit period of 16 system clocks, clock still between frames
// Notes:   Samples the tx wire, oe and strobes mid-slot, just before the bit clock falls
`timescale 1ns/10ps

module spm_link_master (
  input  wire logic        clk_i,
  input  wire logic        tx_data_i,
  input  wire logic        tx_oe_i,
  input  wire logic        strobe1_i,
  input  wire logic        strobe2_i,
  output logic             bit_clk_o,
  output logic             sync_o,
  output logic             rx_data_o,
  output logic             grant_o,
  output logic [19:0]      oe_seen_o,
  output logic [19:0]      line_seen_o,
  output logic [19:0]      s1_seen_o,
  output logic [19:0]      s2_seen_o
);
  // Idle pins: clock low, line pulled up
  initial begin
    bit_clk_o = 1'b0;
    sync_o    = 1'b0;
    rx_data_o = 1'b1;
    grant_o   = 1'b1;
  end

  // Master clock, sync pulse, grant level
  task automatic frame(input logic [19:0] rx, input logic [19:0] gnt);
    for (int s = 0; s < 20; s++) begin
      @(posedge clk_i);
      bit_clk_o <= 1'b1;
      sync_o    <= (s == 0);
      rx_data_o <= rx[19-s];
      grant_o   <= gnt[19-s];
      repeat (7) @(posedge clk_i);
      oe_seen_o[19-s]   <= tx_oe_i;
      line_seen_o[19-s] <= tx_oe_i ? tx_data_i : 1'b1;
      s1_seen_o[19-s]   <= strobe1_i;
      s2_seen_o[19-s]   <= strobe2_i;
      @(posedge clk_i);
      bit_clk_o <= 1'b0;
      sync_o    <= 1'b0;
      repeat (7) @(posedge clk_i);
    end
    // Released rx line goes to its pull-up level
    @(posedge clk_i);
    rx_data_o <= 1'b1;
  endtask
endmodule // spm_link_master

// file: bench/spm_port_bench.sv
// Purpose: Self-checking bench for the port mux and link slave
// Assumes: Link master model on the far side, random ready stalls
// Notes:   Expected rx words queued by the driver, popped by a monitor
`timescale 1ns/10ps
`include "spm_cfg.svh"

module spm_port_bench;
  import spm_pkg::*;
  logic clk_i, rst_n_i, pend, rdy, stall, checking;
  logic [15:0] mask;
  logic [4:0] txb, take;
  logic [2:0] baud, bgo, tcp, mux;
  logic bclk, sync, rxd, gnt, txd, oe, req, s1, s2, abrt, rv, ovr;
  logic [19:0] oe_s, ln_s, s1_s, s2_s;
  logic [31:0] seed, rs;
  spm_mode_t mode;
  spm_route_t route;
  spm_rxw_t rw;
  spm_modem_in_t [2:0] mp, mc;
  spm_modem_out_t [2:0] cm, mpo;
  logic [3:0] exp_q[$];
  int num_errors, n_tests, cyc, aborts, drained, takes;

  // Clock at 100 ns
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  spm_port u_spm_port (.clk_i(clk_i), .rst_n_i(rst_n_i), .mode_i(mode), .route_i(route),
    .bearer_bit_mask_i(mask), .link_bit_clock_i(bclk), .link_frame_sync_i(sync),
    .link_rx_data_i(rxd), .dchan_grant_i(gnt), .link_tx_data_o(txd), .link_tx_oe_o(oe),
    .dchan_request_o(req), .bearer1_strobe_o(s1), .bearer2_strobe_o(s2),
    .ctrl_dchan_pend_i(pend), .ctrl_tx_bit_i(txb), .tx_take_o(take), .dchan_abort_o(abrt),
    .rx_valid_o(rv), .rx_ready_i(rdy), .rx_word_o(rw), .rx_overrun_o(ovr),
    .modem_pin_i(mp), .modem_ctrl_o(mc), .ctrl_modem_i(cm), .modem_pin_o(mpo),
    .baud_clk_i(baud), .baud_gen_clock_out_o(bgo), .tx_clock_pin_o(tcp), .scc_muxed_o(mux));

  spm_link_master u_spm_link_master (.clk_i(clk_i), .tx_data_i(txd), .tx_oe_i(oe),
    .strobe1_i(s1), .strobe2_i(s2), .bit_clk_o(bclk), .sync_o(sync), .rx_data_o(rxd),
    .grant_o(gnt), .oe_seen_o(oe_s), .line_seen_o(ln_s), .s1_seen_o(s1_s), .s2_seen_o(s2_s));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [1:0] r3(input logic [1:0] x);
    return (x == 2'h3) ? 2'h0 : x;
  endfunction

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("counts: %0d compares, %0d mismatches", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Monitor: pop the oldest expected word on every accepted rx word while checking, else count it drained
  always @(posedge clk_i) begin
    cyc++;
    if (abrt === 1'b1) aborts++;
    if ((|take) === 1'b1) takes++;
    if (rv === 1'b1 && rdy === 1'b1) begin
      if (!checking) drained++;
      else if (exp_q.size() == 0) check(rw, 20'hfffff);
      else check(rw, exp_q.pop_front());
    end
    if (cyc == 30000) begin
      num_errors++;
      stop_test;
    end
  end

  // Random consumer stalls
  always @(posedge clk_i) begin
    rs  <= lfsr(rs);
    rdy <= !stall && rs[3];
  end

  // One link frame: queue rx words, check wire, strobes, grant handling
  task automatic run_frame(input logic [19:0] g, input logic pd, input logic lp,
                           input logic ec);
    logic [19:0] rx, oe_x, ln_x;
    logic [2:0] d;
    logic en, gr, dv, ab;
    int nt;
    @(posedge clk_i);
    mode.phy <= interchip_link;
    mode.loop <= lp;
    mode.echo <= ec;
    pend <= pd;
    txb <= seed[24:20];
    mask <= seed[31:16];
    route <= '{dchan: r3(seed[1:0]), b1: r3(seed[3:2]), b2: r3(seed[5:4])};
    rx = seed[19:0];
    seed = lfsr(seed);
    repeat (4) @(posedge clk_i);
    // Request follows pending data in link mode
    check(req, pd);
    gr = pd & g[19];
    ab = 1'b0;
    nt = 0;
    for (int s = 0; s < 20; s++) begin
      en = 1'b1;
      if (s < 8) begin d = route.b1; en = mask[15-s]; end
      else if (s == 9) d = `SPM_DEST_MGMT2;
      else if (s == 19) d = `SPM_DEST_MGMT1;
      else if (s == 8 || s == 18) d = route.dchan;
      else begin d = route.b2; en = mask[17-s]; end
      dv = en;
      if (s == 8 || s == 18) begin
        ab = ab | (gr & !g[19-s]);
        gr = gr & g[19-s];
        dv = gr;
      end
      if (dv && !ec) nt++;
      oe_x[19-s] = ec | dv;
      ln_x[19-s] = dv ? txb[d] : 1'b1;
      if (checking && en) exp_q.push_back({d, lp ? ln_x[19-s] : rx[19-s]});
    end
    aborts = 0;
    takes = 0;
    u_spm_link_master.frame(rx, g);
    repeat (40) @(posedge clk_i);
    check(oe_s, oe_x);
    if (!ec) check(ln_s, ln_x);
    check(s1_s, {mask[15:8], 12'h000});
    check(s2_s, {10'h000, mask[7:0], 2'h0});
    check(aborts, ab);
    check(takes, nt);
    check(exp_q.size(), 0);
  endtask

  initial begin
    logic [2:0] mx;
    logic lp, ec;
    logic [1:0] xo;
    logic [3:0] xi;
    seed = 32'h4547c869;
    rs = lfsr(seed);
    rst_n_i = 1'b0;
    mode = '0;
    route = '0;
    mask = '0;
    pend = 1'b0;
    txb = '0;
    rdy = 1'b0;
    stall = 1'b0;
    checking = 1'b1;
    mp = '1;
    cm = '1;
    baud = '0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // Line floated, strobes low after reset
    check({oe, s1, s2, req}, 4'h0);
    $display("test reset done");
    run_frame(20'hfffff, 1'b1, 1'b0, 1'b0);
    $display("test granted frame done");
    run_frame(20'hffffd, 1'b1, 1'b0, 1'b0);
    $display("test collision frame done");
    run_frame(20'h00000, 1'b1, 1'b0, 1'b0);
    $display("test no grant frame done");
    run_frame(20'hfffff, 1'b0, 1'b1, 1'b0);
    $display("test loopback frame done");
    run_frame(20'hfffff, 1'b0, 1'b0, 1'b1);
    $display("test echo frame done");
    // Buffer fills with the consumer stalled, then drains
    stall <= 1'b1;
    checking <= 1'b0;
    // Three frames give at least twelve words whatever the mask
    repeat (3) run_frame(20'hfffff, 1'b0, 1'b0, 1'b0);
    check(ovr, 1'b1);
    stall <= 1'b0;
    repeat (60) @(posedge clk_i);
    check(drained >= `SPM_FIFO_DEPTH, 1'b1);
    mode.phy <= direct_modem_mode;
    repeat (3) @(posedge clk_i);
    check(ovr, 1'b0);
    $display("test overrun done");
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_i);
      // Direct mode reuses the mux bits as loop and echo
      lp = (k[3:2] == 0) && k[1];
      ec = (k[3:2] == 0) && k[0];
      mode <= '{phy: spm_phy_t'(k[3:2]), serial_ctrl_two_mux: k[1], serial_ctrl_three_mux: k[0], echo: ec,
                loop: lp};
      cm <= seed[5:0];
      mp <= seed[17:6];
      baud <= seed[20:18];
      seed = lfsr(seed);
      repeat (8) @(posedge clk_i);
      mx = (k[3:2] == 0) ? 3'h0 : {k[0], k[1], 1'b1};
      check(mux, mx);
      check(bgo, baud & ~mx);
      check(tcp, baud & mx);
      for (int i = 0; i < 3; i++) begin
        xo = {lp | (ec ? mp[i].rxd : cm[i].txd), ~lp & cm[i].rts};
        xi = {lp ? cm[i].txd : mp[i].rxd, mp[i].rclk, lp | mp[i].cts, lp | mp[i].cd};
        check(mpo[i], mx[i] ? 2'h2 : xo);
        check(mc[i], mx[i] ? 4'h8 : xi);
      end
    end
    $display("test mode table done");
    stop_test;
  end
endmodule // spm_port_bench
